/* core/rpg_port_bank.sv */
// Purpose: per-port back-channel slot sources, stream tagging and line totals
// Assumes: register strobes, stream and frame events are on mclk_i; gpio pins are not
// Notes: outputs are registered; the fifo keeps a registered output stage
`timescale 1ns/1ps

module rpg_fifo
	import rpg_pkg::*;
#(
	parameter int WIDTH = 10,
	parameter int DEPTH = 16
) (
	input wire logic mclk_i, // clock
	input wire logic srst_i, // sync reset
	input wire logic ce_i, // clock enable
	input wire logic in_valid_i, // write offered
	input wire logic [WIDTH-1:0] in_data_i, // write data
	output logic in_ready_o, // room left
	output logic out_valid_o, // output word held
	output logic [WIDTH-1:0] out_data_o, // output word
	input wire logic out_ready_i // consumer takes word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;
	logic [AW:0] next_count;

	assign push = in_valid_i && in_ready_o;
	assign pop = (count != '0) && (!out_valid_o || out_ready_i);
	assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready_o <= 1'b1;
		end else if (ce_i) begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			count <= next_count;
			// ready is a flop, so the source sees full until one cycle after the pop that makes room
			in_ready_o <= next_count < (AW+1)'(DEPTH);
		end
	end

	always_ff @(posedge mclk_i) begin
		if (ce_i && push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			out_valid_o <= 1'b0;
			out_data_o <= '0;
		end else if (ce_i) begin
			if (pop) begin
				out_valid_o <= 1'b1;
				out_data_o <= mem[rd_ptr];
			end else if (out_ready_i) begin
				out_valid_o <= 1'b0;
			end
		end
	end
endmodule : rpg_fifo

// How it works
// - slot code 0xxx forwards local gpio pin numbered by the three low bits
// - code 1000 sends zero, 1001 sends one; every slot resets to constant zero
// - code 1010 sends the frame sync pulse; 1011 to 1111 are reserved
// - low register holds slots 1 and 0, high register slots 3 and 2
// - every port owns its copy; port-select register picks which one host reaches
// - raw10 input tags packets with channel bits 7:6, default the port number
// - raw10 input uses data type bits 5:0, reset value 0x2b
// - raw12 input tags packets with channel bits 7:6, default the port number
// - raw12 input uses data type bits 5:0, reset value 0x2c
// - raw10 identity matters only in raw10 input mode
// - raw12 identity matters only in either raw12 input mode
// - csi-2 channel v becomes map bits 2v+1:2v; reset 0xe4 is identity
// - channel map acts only in csi-2 input mode
// - upper byte of last completed frame's line total reads at 0x73
// - with change interrupt enabled, the total freezes until the host reads it
// - reading the upper byte latches the lower byte for a consistent pair
// - input format 00 csi-2, 01 raw12 low, 10 raw12 high, 11 raw10
module rpg_port_bank
	import rpg_pkg::*;
(
	input wire logic mclk_i, // 50 MHz clock
	input wire logic srst_i, // sync reset, active high
	input wire logic ce_i, // clock enable, low freezes all state
	input wire rpg_req_s req_i, // register strobes from the control engine
	output logic [7:0] rdata_o, // read data
	output logic rvalid_o, // read data valid pulse
	input wire logic [NUM_PINS-1:0] gpio_pin_i, // local gpio pins, asynchronous
	input wire logic camera_sync_pulse_i, // internal frame sync
	input wire logic [NUM_PORTS-1:0][1:0] link_input_format_i, // per-port input format
	input wire logic [NUM_PORTS-1:0] line_total_change_irq_enable_i, // per-port freeze enable
	input wire logic [NUM_PORTS-1:0] line_strobe_i, // per-port line end
	input wire logic [NUM_PORTS-1:0] frame_end_i, // per-port frame end
	output logic [NUM_PORTS-1:0][NUM_SLOTS-1:0] bc_slot_o, // back-channel slot values
	input wire logic in_valid_i, // incoming packet header
	input wire rpg_pkt_s in_pkt_i, // incoming port, channel, type
	output logic in_ready_o, // header accepted
	output logic out_valid_o, // mapped header valid
	output rpg_pkt_s out_pkt_o, // mapped header
	input wire logic out_ready_i // downstream takes header
);
	logic [1:0] port_sel;
	logic [7:0] slot_lo [NUM_PORTS];
	logic [7:0] slot_hi [NUM_PORTS];
	logic [7:0] raw_ten_bit_stream_identity [NUM_PORTS];
	logic [7:0] raw_twelve_bit_stream_identity [NUM_PORTS];
	logic [7:0] vc_map [NUM_PORTS];
	logic [15:0] line_live [NUM_PORTS];
	logic [15:0] line_total [NUM_PORTS];
	logic [7:0] lo_latch [NUM_PORTS];
	logic [NUM_PORTS-1:0] frozen;
	logic [NUM_PINS-1:0] pin_meta;
	logic [NUM_PINS-1:0] pin_sync;
	logic hi_read;
	logic push_raw10;
	rpg_pkt_s mapped;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);

	function automatic logic [3:0] slot_code(input logic [7:0] lo, input logic [7:0] hi,
			input int s);
		logic [15:0] both;
		both = {hi, lo};
		return both[s*SLOT_W +: SLOT_W];
	endfunction : slot_code

	function automatic logic slot_value(input logic [3:0] code, input logic [NUM_PINS-1:0] pins,
			input logic sync);
		logic v;
		v = 1'b0;
		if (!code[3]) begin
			v = pins[code[2:0]];
		end else if (code == SEL_ONE) begin
			v = 1'b1;
		end else if (code == SEL_SYNC) begin
			v = sync;
		end
		// SEL_ZERO and the reserved codes fall through to zero
		return v;
	endfunction : slot_value

	function automatic rpg_pkt_s map_pkt(input rpg_pkt_s p, input logic [1:0] fmt,
			input logic [7:0] r10, input logic [7:0] r12, input logic [7:0] vmap);
		rpg_pkt_s m;
		m = p;
		unique case (rpg_fmt_e'(fmt))
			FMT_CSI2: m.vc = vmap[2*p.vc +: 2];
			FMT_RAW12_LF, FMT_RAW12_HF: begin
				m.vc = r12[TAG_LSB +: 2];
				m.dt = r12[TYPE_LSB +: 6];
			end
			FMT_RAW10: begin
				m.vc = r10[TAG_LSB +: 2];
				m.dt = r10[TYPE_LSB +: 6];
			end
		endcase
		return m;
	endfunction : map_pkt

	assign hi_read = req_i.rd && req_i.addr == LINE_HI_OFS;
	assign push_raw10 = in_valid_i && link_input_format_i[in_pkt_i.port] == 2'h3;
	assign mapped = map_pkt(in_pkt_i, link_input_format_i[in_pkt_i.port],
		raw_ten_bit_stream_identity[in_pkt_i.port], raw_twelve_bit_stream_identity[in_pkt_i.port], vc_map[in_pkt_i.port]);

	// pins come from outside the clock domain
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else if (ce_i) begin
			pin_meta <= gpio_pin_i;
			pin_sync <= pin_meta;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			port_sel <= PORT_SEL_RST;
		end else if (ce_i && req_i.wr && req_i.addr == PORT_SEL_OFS) begin
			port_sel <= req_i.wdata[1:0];
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				slot_lo[p] <= SLOT_RST;
				slot_hi[p] <= SLOT_RST;
				raw_ten_bit_stream_identity[p] <= {2'(p), RAW10_TYPE_RST};
				raw_twelve_bit_stream_identity[p] <= {2'(p), RAW12_TYPE_RST};
				vc_map[p] <= VC_MAP_RST;
			end
		end else if (ce_i && req_i.wr) begin
			// only the selected port's copy is reachable
			unique case (req_i.addr)
				SLOT_LO_OFS: slot_lo[port_sel] <= req_i.wdata;
				SLOT_HI_OFS: slot_hi[port_sel] <= req_i.wdata;
				RAW10_OFS: raw_ten_bit_stream_identity[port_sel] <= req_i.wdata;
				RAW12_OFS: raw_twelve_bit_stream_identity[port_sel] <= req_i.wdata;
				VC_MAP_OFS: vc_map[port_sel] <= req_i.wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			bc_slot_o <= '0;
		end else if (ce_i) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				for (int s = 0; s < NUM_SLOTS; s++) begin
					bc_slot_o[p][s] <= slot_value(slot_code(slot_lo[p], slot_hi[p], s),
						pin_sync, camera_sync_pulse_i);
				end
			end
		end
	end

	// the host read clears freeze in the same cycle, so a frame ending then still lands
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			frozen <= '0;
			for (int p = 0; p < NUM_PORTS; p++) begin
				line_live[p] <= '0;
				line_total[p] <= '0;
				lo_latch[p] <= LINE_RST;
			end
		end else if (ce_i) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (frame_end_i[p]) begin
					line_live[p] <= '0;
				end else if (line_strobe_i[p]) begin
					line_live[p] <= line_live[p] + 16'h0001;
				end
				if (frame_end_i[p] && (!frozen[p] || (hi_read && port_sel == 2'(p)))) begin
					line_total[p] <= line_live[p];
				end
				if (frame_end_i[p] && line_total_change_irq_enable_i[p]
						&& (!frozen[p] || (hi_read && port_sel == 2'(p)))) begin
					frozen[p] <= 1'b1;
				end else if (hi_read && port_sel == 2'(p)) begin
					frozen[p] <= 1'b0;
				end
				if (hi_read && port_sel == 2'(p)) begin
					lo_latch[p] <= line_total[p][7:0];
				end
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			rdata_o <= '0;
			rvalid_o <= 1'b0;
		end else if (ce_i) begin
			rvalid_o <= req_i.rd;
			if (req_i.rd) begin
				unique case (req_i.addr)
					PORT_SEL_OFS: rdata_o <= {6'h00, port_sel};
					SLOT_LO_OFS: rdata_o <= slot_lo[port_sel];
					SLOT_HI_OFS: rdata_o <= slot_hi[port_sel];
					RAW10_OFS: rdata_o <= raw_ten_bit_stream_identity[port_sel];
					RAW12_OFS: rdata_o <= raw_twelve_bit_stream_identity[port_sel];
					VC_MAP_OFS: rdata_o <= vc_map[port_sel];
					LINE_HI_OFS: rdata_o <= line_total[port_sel][15:8];
					LINE_LO_OFS: rdata_o <= lo_latch[port_sel];
					default: rdata_o <= 8'h00;
				endcase
			end
		end
	end

	rpg_fifo #(
		.WIDTH($bits(rpg_pkt_s)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.ce_i(ce_i),
		.in_valid_i(in_valid_i),
		.in_data_i(mapped),
		.in_ready_o(in_ready_o),
		.out_valid_o(out_valid_o),
		.out_data_o(out_pkt_o),
		.out_ready_i(out_ready_i)
	);

	slot_pin_a: assert property (ce_i && !slot_lo[1][3]
		|=> bc_slot_o[1][0] == $past(pin_sync[slot_lo[1][2:0]]))
		else $error("slot pin forward wrong");
	slot_zero_a: assert property (ce_i && slot_lo[1][3:0] == SEL_ZERO
		|=> !bc_slot_o[1][0]) else $error("slot constant zero wrong");
	slot_one_a: assert property (ce_i && slot_lo[1][7:4] == SEL_ONE
		|=> bc_slot_o[1][1]) else $error("slot constant one wrong");
	slot_sync_a: assert property (ce_i && slot_hi[1][7:4] == SEL_SYNC
		|=> bc_slot_o[1][3] == $past(camera_sync_pulse_i)) else $error("slot sync wrong");
	slot_rsvd_a: assert property (ce_i && slot_lo[1][3:0] > SEL_SYNC
		|=> !bc_slot_o[1][0]) else $error("reserved slot not zero");
	raw10_tag_a: assert property (ce_i && push_raw10
		|-> mapped.vc == raw_ten_bit_stream_identity[in_pkt_i.port][7:6]
		&& mapped.dt == raw_ten_bit_stream_identity[in_pkt_i.port][5:0]) else $error("raw10 tag wrong");
	raw12_tag_a: assert property (ce_i && in_valid_i
		&& link_input_format_i[in_pkt_i.port] inside {2'h1, 2'h2}
		|-> mapped.vc == raw_twelve_bit_stream_identity[in_pkt_i.port][7:6]
		&& mapped.dt == raw_twelve_bit_stream_identity[in_pkt_i.port][5:0]) else $error("raw12 tag wrong");
	vc_map_a: assert property (ce_i && in_valid_i && link_input_format_i[in_pkt_i.port] == 2'h0
		|-> mapped.vc == vc_map[in_pkt_i.port][2*in_pkt_i.vc +: 2]
		&& mapped.dt == in_pkt_i.dt) else $error("csi channel map wrong");
	line_capture_a: assert property (ce_i && frame_end_i[3] && !frozen[3]
		|=> line_total[3] == $past(line_live[3])) else $error("line total not captured");
	line_freeze_a: assert property (ce_i && frozen[3] && !(hi_read && port_sel == 2'h3)
		|=> $stable(line_total[3])) else $error("frozen total changed");
	lo_latch_a: assert property (ce_i && hi_read
		|=> {rdata_o, lo_latch[$past(port_sel)]} == $past(line_total[port_sel]))
		else $error("lower byte not latched with upper");
	port_sel_a: assert property (ce_i && req_i.wr && req_i.addr == PORT_SEL_OFS
		|=> port_sel == $past(req_i.wdata[1:0])) else $error("port select not taken");
	read_valid_a: assert property (ce_i && req_i.rd
		|=> rvalid_o) else $error("read not answered");
	ce_freeze_a: assert property (!ce_i |=> $stable(bc_slot_o) && $stable(rdata_o)
		&& $stable(in_ready_o) && $stable(out_valid_o)) else $error("state moved without enable");

	fifo_full_c: cover property (ce_i && !in_ready_o ##[1:40] in_ready_o);
	freeze_c: cover property (frozen[3] ##[1:100] hi_read && port_sel == 2'h3);
	sync_slot_c: cover property (slot_hi[1][7:4] == SEL_SYNC && bc_slot_o[1][3]);
	remap_c: cover property (out_valid_o && out_ready_i && out_pkt_o.vc == 2'h3);
endmodule : rpg_port_bank

/* include/rpg_pkg.sv */
// Purpose: constants and types for the per-port gpio slot and channel mapping bank
// Assumes: 8-bit register port fed by the device's serial control engine
// Notes: four receive ports, each with its own live copy; the port-select register picks the one the host reaches
package rpg_pkg;
	localparam int NUM_PORTS = 4;
	localparam int NUM_SLOTS = 4;
	localparam int NUM_PINS = 8;
	localparam int FIFO_DEPTH = 16;
	localparam logic [7:0] PORT_SEL_OFS = 8'h4c;
	localparam logic [7:0] SLOT_LO_OFS = 8'h6e;
	localparam logic [7:0] SLOT_HI_OFS = 8'h6f;
	localparam logic [7:0] RAW10_OFS = 8'h70;
	localparam logic [7:0] RAW12_OFS = 8'h71;
	localparam logic [7:0] VC_MAP_OFS = 8'h72;
	localparam logic [7:0] LINE_HI_OFS = 8'h73;
	localparam logic [7:0] LINE_LO_OFS = 8'h74;
	localparam logic [7:0] SLOT_RST = 8'h88;
	localparam logic [5:0] RAW10_TYPE_RST = 6'h2b;
	localparam logic [5:0] RAW12_TYPE_RST = 6'h2c;
	localparam logic [7:0] VC_MAP_RST = 8'he4;
	localparam logic [7:0] LINE_RST = 8'h00;
	localparam logic [1:0] PORT_SEL_RST = 2'h0;
	localparam int TAG_LSB = 6;
	localparam int TYPE_LSB = 0;
	localparam int SLOT_W = 4;
	localparam logic [3:0] SEL_ZERO = 4'h8;
	localparam logic [3:0] SEL_ONE = 4'h9;
	localparam logic [3:0] SEL_SYNC = 4'ha;

	typedef enum logic [1:0] {
		FMT_CSI2 = 2'h0,
		FMT_RAW12_LF = 2'h1,
		FMT_RAW12_HF = 2'h2,
		FMT_RAW10 = 2'h3
	} rpg_fmt_e;

	typedef struct packed {
		logic [1:0] port;
		logic [1:0] vc;
		logic [5:0] dt;
	} rpg_pkt_s;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} rpg_req_s;
endpackage : rpg_pkg

/* testbench/rpg_ser_model.sv */
// Purpose: remote serializer end of the back channel, one slot register per port
// Assumes: slot values arrive on mclk_i as the hub sends them
// Notes: one cycle of link delay; the bench reads the remote pins, and bc_slot_o only right after reset
`timescale 1ns/1ps
module rpg_ser_model
	import rpg_pkg::*;
(
	input wire logic mclk_i, // clock
	input wire logic [NUM_PORTS-1:0][NUM_SLOTS-1:0] bc_slot_i, // back-channel slots
	output logic [NUM_PORTS-1:0][NUM_SLOTS-1:0] remote_gpio_o // remote pins
);
	// remote pins follow the link with a fixed lag
	always_ff @(posedge mclk_i) begin
		remote_gpio_o <= bc_slot_i;
	end
endmodule : rpg_ser_model

/* testbench/tb.sv */
// Purpose: self-checking bench for the per-port slot and stream mapping bank
// Assumes: one register strobe at a time, inputs driven 1 ns after the edge
// Notes: a frame of at least 256 lines is needed to reach the upper line-total byte; the bench uses 300
`timescale 1ns/1ps
module tb
	import rpg_pkg::*;
;
	logic mclk_i = 0, srst = 1, ce = 1, sync = 0, rvalid, in_valid = 0, in_ready;
	logic out_valid, out_ready = 1;
	rpg_req_s req = '0;
	logic [7:0] rdata, gpio = '0, ra[7], rv[7];
	logic [3:0][1:0] fmt = '0;
	logic [3:0] ie = '0, ls = '0, fe = '0;
	logic [3:0][3:0] bc, remote;
	rpg_pkt_s in_pkt = '0, out_pkt;
	int errors = 0, checks_done = 0, cyc = 0, n;
	logic e;
	initial forever #10 mclk_i = ~mclk_i;
	rpg_port_bank i_rpg_port_bank (.mclk_i(mclk_i), .srst_i(srst), .ce_i(ce), .req_i(req),
		.rdata_o(rdata), .rvalid_o(rvalid), .gpio_pin_i(gpio), .camera_sync_pulse_i(sync),
		.link_input_format_i(fmt), .line_total_change_irq_enable_i(ie), .line_strobe_i(ls),
		.frame_end_i(fe), .bc_slot_o(bc), .in_valid_i(in_valid), .in_pkt_i(in_pkt),
		.in_ready_o(in_ready), .out_valid_o(out_valid), .out_pkt_o(out_pkt),
		.out_ready_i(out_ready));
	rpg_ser_model i_rpg_ser_model (.mclk_i(mclk_i), .bc_slot_i(bc), .remote_gpio_o(remote));
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
		checks_done++;
		if (g !== x) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, x, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		#1 req.addr = a;
		req.wdata = d;
		req.wr = 1'b1;
		@(posedge mclk_i);
		#1 req.wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] x, input string nm);
		int k;
		k = 0;
		@(posedge mclk_i);
		#1 req.addr = a;
		req.rd = 1'b1;
		@(posedge mclk_i);
		#1 req.rd = 1'b0;
		while (rvalid !== 1'b1 && k < 4) begin
			@(posedge mclk_i);
			#1 k++;
		end
		chk({nm, " valid"}, 16'h1, 16'(rvalid));
		chk(nm, 16'(x), 16'(rdata));
	endtask : rd
	function automatic rpg_pkt_s pk(input logic [1:0] p, v, input logic [5:0] d);
		return '{port: p, vc: v, dt: d};
	endfunction : pk
	task automatic send(input rpg_pkt_s p);
		@(posedge mclk_i);
		#1 in_pkt = p;
		in_valid = 1'b1;
		// ready is looked at off the edge, where it has settled
		while (in_ready !== 1'b1) begin
			@(posedge mclk_i);
			#1;
		end
		@(posedge mclk_i);
		#1 in_valid = 1'b0;
	endtask : send
	task automatic recv(input rpg_pkt_s x, input string nm);
		int k;
		k = 0;
		while (out_valid !== 1'b1 && k < 20) begin
			@(posedge mclk_i);
			#1 k++;
		end
		chk({nm, " valid"}, 16'h1, 16'(out_valid));
		chk(nm, 16'(x), 16'(out_pkt));
		@(posedge mclk_i);
		#1;
	endtask : recv
	task automatic frame(input int k);
		repeat (k) begin
			ls[3] = 1'b1;
			@(posedge mclk_i);
			#1 ls[3] = 1'b0;
			@(posedge mclk_i);
			#1;
		end
		fe[3] = 1'b1;
		@(posedge mclk_i);
		#1 fe[3] = 1'b0;
	endtask : frame
	// hang guard: a full run needs well under 5000 cycles
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc > 20000) begin
			errors++;
			tally_and_finish();
		end
	end
	initial begin
		ra = '{SLOT_LO_OFS, SLOT_HI_OFS, RAW10_OFS, RAW12_OFS, VC_MAP_OFS, LINE_HI_OFS, 8'h50};
		rv = '{8'h88, 8'h88, 8'h2b, 8'h2c, 8'he4, 8'h00, 8'h00};
		repeat (8) @(posedge mclk_i);
		#1 srst = 0;
		chk("bc after reset", 16'h0, 16'(bc));
		foreach (ra[i]) rd(ra[i], rv[i], "reset value");
		wr(LINE_HI_OFS, 8'hff);
		rd(LINE_HI_OFS, 8'h00, "read-only total");
		wr(PORT_SEL_OFS, 8'h02);
		rd(RAW10_OFS, 8'hab, "port2 raw_ten_bit_stream_identity");
		rd(RAW12_OFS, 8'hac, "port2 raw_twelve_bit_stream_identity");
		$display("test reset values done");
		wr(PORT_SEL_OFS, 8'h01);
		gpio = 8'h35;
		sync = 1'b1;
		for (int c = 0; c < 16; c++) begin
			wr(SLOT_LO_OFS, {4'h9, 4'(c)});
			wr(SLOT_HI_OFS, {4'(c), 4'h8});
			// both sync levels, so a constant cannot pass for the sync source
			for (int s = 0; s < 2; s++) begin
				sync = s[0];
				repeat (6) @(posedge mclk_i);
				#1 e = c < 8 ? gpio[c % 8] : (c == 9 || (c == 10 && sync));
				chk("slot0", 16'(e), 16'(remote[1][0]));
				chk("slot3", 16'(e), 16'(remote[1][3]));
				chk("slot1 one", 16'h1, 16'(remote[1][1]));
				chk("slot2 zero", 16'h0, 16'(remote[1][2]));
				chk("port0 slots", 16'h0, 16'(remote[0]));
			end
		end
		rd(SLOT_LO_OFS, 8'h9f, "slot low reg");
		rd(SLOT_HI_OFS, 8'hf8, "slot high reg");
		$display("test slot sources done");
		wr(PORT_SEL_OFS, 8'h00);
		wr(RAW10_OFS, 8'hc5);
		wr(RAW12_OFS, 8'h4a);
		wr(VC_MAP_OFS, 8'h1b);
		for (int f = 0; f < 4; f++) begin
			fmt[0] = 2'(f);
			send(pk(2'h0, 2'h1, 6'h3f));
			recv(f == 3 ? pk(2'h0, 2'h3, 6'h05) : f == 0 ? pk(2'h0, 2'h2, 6'h3f) :
				pk(2'h0, 2'h1, 6'h0a), "mode tag");
		end
		fmt = {2'h3, 2'h3, 2'h3, 2'h0};
		send(pk(2'h2, 2'h0, 6'h00));
		recv(pk(2'h2, 2'h2, 6'h2b), "port2 raw10 default");
		ce = 1'b0;
		wr(RAW10_OFS, 8'h00);
		ce = 1'b1;
		rd(RAW10_OFS, 8'hc5, "write held off by enable");
		$display("test stream tagging done");
		out_ready = 1'b0;
		n = 0;
		in_valid = 1'b1;
		repeat (40) begin
			in_pkt = pk(2'h0, n[1:0], n[5:0]);
			e = in_ready;
			@(posedge mclk_i);
			#1;
			if (e === 1'b1) n++;
		end
		in_valid = 1'b0;
		chk("fifo accepted", 16'(FIFO_DEPTH + 1), 16'(n));
		out_ready = 1'b1;
		for (int i = 0; i < n; i++) recv(pk(2'h0, ~2'(i), 6'(i)), "drain order");
		chk("fifo empty", 16'h0, 16'(out_valid));
		$display("test fifo fill and drain done");
		wr(PORT_SEL_OFS, 8'h03);
		frame(300);
		rd(LINE_HI_OFS, 8'h01, "total upper");
		frame(2);
		rd(LINE_LO_OFS, 8'h2c, "latched lower");
		rd(LINE_HI_OFS, 8'h00, "new total upper");
		rd(LINE_LO_OFS, 8'h02, "new total lower");
		ie[3] = 1'b1;
		frame(5);
		frame(7);
		rd(LINE_HI_OFS, 8'h00, "frozen upper");
		rd(LINE_LO_OFS, 8'h05, "frozen lower");
		frame(9);
		rd(LINE_HI_OFS, 8'h00, "after read upper");
		rd(LINE_LO_OFS, 8'h09, "after read lower");
		$display("test line totals done");
		tally_and_finish();
	end
endmodule : tb
